// ---- design/cdrr_regs.sv ----
// Result register bank of the cable reflectometry engine, Wishbone slave.
// Assumes the engine pulses run_start_i when a run begins and done_pulse_i
// with valid results on result_i when it ends; one clock, sync reset.
//
// Contract
// - Results are valid only after the done flag reads one.
// - Reg 0x181: tx location 4 high byte, tx location 3 low byte.
// - Mixed reg: rx location 1 high byte, tx location 5 low byte.
// - Reg 0x183: rx location 3 high byte, rx location 2 low byte.
// - Reg 0x184: rx location 5 high byte, rx location 4 low byte.
// - Reg 0x185: tx amplitude 2 in 14:8, tx amplitude 1 in 6:0.
// - Amplitude bits 15 and 7 ignore writes and read zero.
// - Low amplitude pairs low location byte, high pairs high byte.
// - Location fields carry distance codes to each reflection.
// - Amplitude fields carry reflection strength codes.
// - Reg 0x180: tx location 2 high byte, tx location 1 low.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "cdrr_map.svh"

module cdrr_regs
  import cdrr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Wishbone slave
  input  wire cdrr_wb_req_s wb_req_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Reflectometry engine
  input  wire logic         run_start_i,
  input  wire logic         done_pulse_i,
  input  wire cdrr_result_s result_i,
  // Status
  output logic              diag_done_o
);

  // ==========================================================
  // Result storage
  cdrr_loc_t [4:0] tx_loc;
  cdrr_loc_t [4:0] rx_loc;
  cdrr_amp_t [1:0] tx_amp;
  logic            done;

  // Captured once per run and then frozen
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_loc
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tx_loc[gi] <= `CDRR_LOC_RESET;
          rx_loc[gi] <= `CDRR_LOC_RESET;
        end else if (ce_i && done_pulse_i) begin
          tx_loc[gi] <= result_i.tx_loc[gi];
          rx_loc[gi] <= result_i.rx_loc[gi];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_amp
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tx_amp[gi] <= `CDRR_AMP_RESET;
        end else if (ce_i && done_pulse_i) begin
          tx_amp[gi] <= result_i.tx_amp[gi];
        end
      end
    end
  endgenerate

  // Done flag: completion wins over a simultaneous new start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done <= 1'b0;
    end else if (ce_i) begin
      if (done_pulse_i) begin
        done <= 1'b1;
      end else if (run_start_i) begin
        done <= 1'b0;
      end
    end
  end

  assign diag_done_o = done;

  // ==========================================================
  // Register read decode
  function automatic logic [15:0] loc_pair(input cdrr_loc_t hi,
                                           input cdrr_loc_t lo);
    loc_pair = {hi, lo};
  endfunction

  wire logic        req;
  wire logic [15:0] rd_word;
  wire logic [15:0] amp_word;

  assign req = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  // Reserved amplitude bits are constant zero
  assign amp_word = {1'b0, tx_amp[1], 1'b0, tx_amp[0]};

  assign rd_word =
    (wb_req_i.adr == `CDRR_IDX_TX_LOC_1_2) ?
      loc_pair(tx_loc[1], tx_loc[0]) :
    (wb_req_i.adr == `CDRR_IDX_TX_LOC_3_4) ?
      loc_pair(tx_loc[3], tx_loc[2]) :
    (wb_req_i.adr == `CDRR_IDX_MIXED_LOC) ?
      loc_pair(rx_loc[0], tx_loc[4]) :
    (wb_req_i.adr == `CDRR_IDX_RX_LOC_2_3) ?
      loc_pair(rx_loc[2], rx_loc[1]) :
    (wb_req_i.adr == `CDRR_IDX_RX_LOC_4_5) ?
      loc_pair(rx_loc[4], rx_loc[3]) :
    (wb_req_i.adr == `CDRR_IDX_TX_AMP_1_2) ? amp_word :
    (wb_req_i.adr == `CDRR_IDX_STATUS) ? {15'h0000, done} :
    `CDRR_RESET_VALUE;

  // ==========================================================
  // Bus answer: one wait state, writes everywhere are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req && !wb_req_i.we) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_run_end;
    ce_i && done_pulse_i;
  endsequence

  a_done_on_end: assert property (@(posedge clk_i) disable iff (rst_i)
    s_run_end |=> done)
    else $error("done flag not set after run end");
  a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && run_start_i && !done_pulse_i |=> !done)
    else $error("done flag not cleared at run start");
  a_hold_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ce_i && done_pulse_i) |=> $stable(tx_loc) && $stable(rx_loc)
      && $stable(tx_amp))
    else $error("results changed without a run end");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_loc_3_4: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we
      && wb_req_i.adr == `CDRR_IDX_TX_LOC_3_4
    |=> wb_dat_o == {16'h0000, $past(tx_loc[3]), $past(tx_loc[2])})
    else $error("wrong tx location 3/4 word");
  a_mixed_loc: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we && wb_req_i.adr == `CDRR_IDX_MIXED_LOC
    |=> wb_dat_o == {16'h0000, $past(rx_loc[0]), $past(tx_loc[4])})
    else $error("wrong mixed location word");
  a_loc_rx_2_3: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we
      && wb_req_i.adr == `CDRR_IDX_RX_LOC_2_3
    |=> wb_dat_o[15:0] == {$past(rx_loc[2]), $past(rx_loc[1])})
    else $error("wrong rx location 2/3 word");
  a_loc_rx_4_5: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we
      && wb_req_i.adr == `CDRR_IDX_RX_LOC_4_5
    |=> wb_dat_o[15:0] == {$past(rx_loc[4]), $past(rx_loc[3])})
    else $error("wrong rx location 4/5 word");
  a_amp_layout: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we
      && wb_req_i.adr == `CDRR_IDX_TX_AMP_1_2
    |=> wb_dat_o[15] == 1'b0 && wb_dat_o[7] == 1'b0
      && wb_dat_o[14:8] == $past(tx_amp[1])
      && wb_dat_o[6:0] == $past(tx_amp[0]))
    else $error("wrong amplitude word");
  a_loc_1_2: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req && !wb_req_i.we
      && wb_req_i.adr == `CDRR_IDX_TX_LOC_1_2
    |=> wb_dat_o[15:0] == {$past(tx_loc[1]), $past(tx_loc[0])})
    else $error("wrong tx location 1/2 word");

  // ==========================================================
  // Reset, bus, freeze, capture and done flag checks
  function automatic logic idx_mapped(input logic [11:2] adr);
    idx_mapped = adr inside {`CDRR_IDX_TX_LOC_1_2, `CDRR_IDX_TX_LOC_3_4,
                             `CDRR_IDX_MIXED_LOC, `CDRR_IDX_RX_LOC_2_3,
                             `CDRR_IDX_RX_LOC_4_5, `CDRR_IDX_TX_AMP_1_2,
                             `CDRR_IDX_STATUS};
  endfunction

  sequence s_take;
    ce_i && req;
  endsequence

  sequence s_read;
    s_take ##0 !wb_req_i.we;
  endsequence

  sequence s_write;
    s_take ##0 wb_req_i.we;
  endsequence

  // Reset leaves every result, the flag and the bus outputs at zero
  a_reset_clear: assert property (@(posedge clk_i)
    rst_i |=> tx_loc == '0 && rx_loc == '0 && tx_amp == '0
      && !done && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("state not cleared by reset");

  // A taken request is answered in the next cycle
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_take |=> wb_ack_o)
    else $error("request not acknowledged");

  // No answer without a request
  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !req |=> !wb_ack_o)
    else $error("ack without a request");

  // Enable low freezes everything
  a_freeze_all: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(done) && $stable(wb_ack_o) && $stable(wb_dat_o)
      && $stable(tx_loc) && $stable(rx_loc) && $stable(tx_amp))
    else $error("state moved while disabled");

  // Run end copies the engine results
  a_capture_all: assert property (@(posedge clk_i) disable iff (rst_i)
    s_run_end |=> tx_loc == $past(result_i.tx_loc)
      && rx_loc == $past(result_i.rx_loc)
      && tx_amp == $past(result_i.tx_amp))
    else $error("results not captured at run end");

  // A new run start leaves the old results in place
  a_start_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && run_start_i && !done_pulse_i
    |=> $stable(tx_loc) && $stable(rx_loc) && $stable(tx_amp))
    else $error("results changed at run start");

  // Done stays up until a new run starts
  a_done_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    done && !(ce_i && run_start_i) |=> done)
    else $error("done flag lost without a new run");

  // Done rises only on a run end
  a_done_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done) |-> $past(ce_i && done_pulse_i))
    else $error("done flag set without a run end");

  // Done falls only on a run start or reset
  a_done_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(done)
    |-> $past(ce_i && run_start_i && !done_pulse_i) || $past(rst_i))
    else $error("done flag cleared without a run start");

  // Status word carries the flag in bit zero
  a_status_word: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read ##0 wb_req_i.adr == `CDRR_IDX_STATUS
    |=> wb_dat_o == {31'h0, $past(done)})
    else $error("wrong status word");

  // Unmapped indices read zero
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read ##0 !idx_mapped(wb_req_i.adr)
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  // Reserved amplitude bits read zero
  a_amp_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read ##0 wb_req_i.adr == `CDRR_IDX_TX_AMP_1_2
    |=> !wb_dat_o[15] && !wb_dat_o[7])
    else $error("reserved amplitude bit set");

  // Writes are acknowledged and leave the read data alone
  a_write_no_dat: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write |=> $stable(wb_dat_o))
    else $error("write changed read data");

  // Read data holds while the bus is idle
  a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !req |=> $stable(wb_dat_o))
    else $error("read data moved while idle");

  // Registers sit in the low half of the bus word
  a_upper_half: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

endmodule
`default_nettype wire

// ---- common/cdrr_map.svh ----
// Register map constants for the cable diagnostic result register bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CDRR_MAP_SVH
`define CDRR_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CDRR_IDX_TX_LOC_1_2    10'h180
`define CDRR_IDX_TX_LOC_3_4    10'h181
`define CDRR_IDX_MIXED_LOC     10'h182
`define CDRR_IDX_RX_LOC_2_3    10'h183
`define CDRR_IDX_RX_LOC_4_5    10'h184
`define CDRR_IDX_TX_AMP_1_2    10'h185
`define CDRR_IDX_STATUS        10'h1ff

// ==========================================================
// Field positions and reset values
`define CDRR_LOC_HI_MSB        15
`define CDRR_LOC_HI_LSB        8
`define CDRR_LOC_LO_MSB        7
`define CDRR_LOC_LO_LSB        0
`define CDRR_AMP_HI_MSB        14
`define CDRR_AMP_HI_LSB        8
`define CDRR_AMP_LO_MSB        6
`define CDRR_AMP_LO_LSB        0
`define CDRR_STAT_DONE_BIT     0
`define CDRR_RESET_VALUE       16'h0000
`define CDRR_LOC_RESET         8'h00
`define CDRR_AMP_RESET         7'h00

`endif

// ---- common/cdrr_pkg.sv ----
// Types for the cable diagnostic result register bank.
// Assumes cdrr_map.svh is on the include path.
`include "cdrr_map.svh"

package cdrr_pkg;
  typedef logic [7:0] cdrr_loc_t;
  typedef logic [6:0] cdrr_amp_t;

  // Results delivered by the reflectometry engine at the end of a run
  typedef struct packed {
    cdrr_loc_t [4:0] tx_loc;
    cdrr_loc_t [4:0] rx_loc;
    cdrr_amp_t [1:0] tx_amp;
  } cdrr_result_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:2] adr;
    logic [31:0] dat;
  } cdrr_wb_req_s;
endpackage

// ---- verif/cdrr_regs_tb_top.sv ----
// Self-checking bench for the cable diagnostic result register bank.
// Assumes cdrr_pkg and cdrr_map.svh are compiled and on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "cdrr_map.svh"

module cdrr_regs_tb_top
  import cdrr_pkg::*;
;
  // ==========================================================
  // Stimulus and hookup
  logic         clk_i        = 1'b0;
  logic         rst_i        = 1'b1;
  logic         ce_i         = 1'b1;
  cdrr_wb_req_s req          = '0;
  logic         run_start_i  = 1'b0;
  logic         done_pulse_i = 1'b0;
  cdrr_result_s res          = '0;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  logic         diag_done_o;
  cdrr_result_s r1;
  int           mismatches   = 0;
  int           check_count  = 0;

  always #5 clk_i = ~clk_i;

  cdrr_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .run_start_i(run_start_i), .done_pulse_i(done_pulse_i),
    .result_i(res), .diag_done_o(diag_done_o));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic we, input logic [9:0] idx,
                    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hf, adr:idx, dat:wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    req <= '0;
    chk({31'h0, wb_ack_o}, 32'h1);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic check_map(input cdrr_result_s r, input logic done);
    rd(`CDRR_IDX_TX_LOC_1_2, {16'h0, r.tx_loc[1], r.tx_loc[0]});
    rd(`CDRR_IDX_TX_LOC_3_4, {16'h0, r.tx_loc[3], r.tx_loc[2]});
    rd(`CDRR_IDX_MIXED_LOC, {16'h0, r.rx_loc[0], r.tx_loc[4]});
    rd(`CDRR_IDX_RX_LOC_2_3, {16'h0, r.rx_loc[2], r.rx_loc[1]});
    rd(`CDRR_IDX_RX_LOC_4_5, {16'h0, r.rx_loc[4], r.rx_loc[3]});
    rd(`CDRR_IDX_TX_AMP_1_2,
       {17'h0, r.tx_amp[1], 1'b0, r.tx_amp[0]});
    rd(`CDRR_IDX_STATUS, {31'h0, done});
  endtask

  task automatic pulse(input logic start, input cdrr_result_s r);
    @(posedge clk_i);
    run_start_i <= start;
    done_pulse_i <= ~start;
    res <= r;
    @(posedge clk_i);
    run_start_i <= 1'b0;
    done_pulse_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({31'h0, diag_done_o}, {31'h0, ~start});
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_capture();
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      r1.tx_loc[i] = 8'hc0 ^ 8'(i * 17);
      r1.rx_loc[i] = 8'h35 ^ 8'(i * 34);
    end
    r1.tx_amp = {7'h2a, 7'h7f};
    pulse(1'b0, r1);
    check_map(r1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 10'h180 + 10'(i), 32'hffff_ffff, d);
    end
    check_map(r1, 1'b1);
    $display("test capture done");
  endtask

  task automatic test_rerun();
    pulse(1'b1, ~r1);
    check_map(r1, 1'b0);
    rd(10'h100, 32'h0);
    pulse(1'b0, ~r1);
    check_map(~r1, 1'b1);
    $display("test rerun done");
  endtask

  task automatic test_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    done_pulse_i <= 1'b1;
    res <= r1;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    done_pulse_i <= 1'b0;
    check_map(~r1, 1'b1);
    $display("test freeze done");
  endtask

  initial begin
    do_reset();
    check_map('0, 1'b0);
    test_capture();
    test_rerun();
    test_freeze();
    do_reset();
    check_map('0, 1'b0);
    $display("test reset done");
    end_sim();
  end

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
